// [shared/dsp_params.svh]
// Register offsets, reset values, fixed TOP values and mode codes
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH
`define DSP_OFF_CTRL     8'h00
`define DSP_OFF_COUNT    8'h04
`define DSP_OFF_CMPA     8'h08
`define DSP_OFF_CMPB     8'h0C
`define DSP_OFF_CAPT     8'h10
`define DSP_OFF_FLAGS    8'h14
`define DSP_CTRL_RST     10'h000
`define DSP_CNT_RST      16'h0000
`define DSP_CMP_RST      16'h0000
`define DSP_FLG_RST      4'h0
`define DSP_TOP_8BIT     16'h00FF
`define DSP_TOP_9BIT     16'h01FF
`define DSP_TOP_10BIT    16'h03FF
`define DSP_BOTTOM       16'h0000
`define DSP_WM_PC8       4'h1
`define DSP_WM_PC9       4'h2
`define DSP_WM_PC10      4'h3
`define DSP_WM_PFC_CAP   4'h8
`define DSP_WM_PFC_CMPA  4'h9
`define DSP_WM_PC_CAP    4'hA
`define DSP_WM_PC_CMPA   4'hB
`define DSP_OM_OFF       2'h0
`define DSP_OM_TOGGLE    2'h1
`define DSP_OM_NONINV    2'h2
`define DSP_OM_INV       2'h3
`endif

// [shared/dsp_pkg.sv]
// Types shared by the dual-slope PWM timer
package dsp_pkg;
   typedef enum logic {DSP_UP, DSP_DOWN} dsp_dir_t;
   // Control word: bits 9:8 pin dirs, 7:6 mode B, 5:4 mode A, 3:0 wave mode
   typedef struct packed {
      logic       pin_direction_bit_b;
      logic       pin_direction_bit_a;
      logic [1:0] output_mode_bits_b;
      logic [1:0] output_mode_bits_a;
      logic [3:0] waveform_mode_select;
   } dsp_ctrl_t;
   // Flags: bit 3 capture, 2 compare B, 1 compare A, 0 overflow
   typedef struct packed {
      logic capture_flag;
      logic cmp_flag_b;
      logic cmp_flag_a;
      logic overflow_flag;
   } dsp_flags_t;
endpackage

// [rtl/dsp_pwm_timer.sv]
// Dual-slope 16-bit PWM timer with APB register access
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dsp_params.svh"
// Summary of operation
// RULE1 - Codes 1,2,3,10,11 count up then down
// RULE2 - Phase correct TOP: fixed, capture or A
// RULE3 - Counter holds TOP one tick, then down
// RULE4 - Register TOP between 0x0003 and 0xFFFF
// RULE5 - Non-inverting clears up, sets down; inverse
// RULE6 - Phase correct sets overflow at BOTTOM
// RULE7 - Phase correct loads compares at TOP, flags
// RULE8 - Fixed TOP masks written compare high bits
// RULE9 - Slopes follow old then new TOP
// RULE10 - Software prefers frequency correct for TOP changes
// RULE11 - Software keeps TOP above compare values
// RULE12 - Compare BOTTOM low, TOP high, non-inverted
// RULE13 - Code 11, mode 1 toggles output A
// RULE14 - Codes 8,9 frequency correct; capture or A
// RULE15 - Frequency correct TOP only from register
// RULE16 - Frequency correct loads at BOTTOM, overflow
// RULE17 - Frequency correct flags A/capture at TOP
// RULE18 - Compare flag set on every match
// RULE19 - Frequency correct extremes give constant levels
// RULE20 - Code 9, mode 1 toggles output A
// RULE21 - Output modes 00 off, 10, 11 polarity
// RULE22 - Everything advances only on timer tick
module dsp_pwm_timer import dsp_pkg::*; (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Prescaled timer clock enable
   input  wire logic        timer_tick,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Compare output pins
   output logic             compare_output_a,
   output logic             compare_output_a_oe,
   output logic             compare_output_b,
   output logic             compare_output_b_oe
);

   // ****************************************
   // State
   // ****************************************
   dsp_ctrl_t   ctrl;
   dsp_flags_t  flags;
   dsp_dir_t    dir;
   logic [15:0] counter_value;
   logic [15:0] capture_value_register;
   logic [15:0] cmp_buf_a;
   logic [15:0] cmp_buf_b;
   logic [15:0] compare_register_a;
   logic [15:0] compare_register_b;
   logic [15:0] top;
   logic [15:0] wr_mask;
   logic        pc_mode;
   logic        pfc_mode;
   logic        dual;
   logic        at_top;
   logic        at_bottom;
   logic        match_a;
   logic        match_b;
   logic        top_cap;
   logic        top_cmpa;
   logic        toggle_ok;
   logic        wr;
   logic        setup;
   logic        mapped;
   logic        wr_cnt;
   logic [3:0]  wm;

   assign wm = ctrl.waveform_mode_select;

   // ****************************************
   // Mode decode and TOP select
   // ****************************************
   always_comb begin
      pc_mode  = 1'b0;
      pfc_mode = 1'b0;
      top      = `DSP_TOP_8BIT;
      wr_mask  = 16'hFFFF;
      case (wm)
         `DSP_WM_PC8: begin
            pc_mode = 1'b1; // see RULE1
            top     = `DSP_TOP_8BIT; // see RULE2
            wr_mask = `DSP_TOP_8BIT;
         end
         `DSP_WM_PC9: begin
            pc_mode = 1'b1;
            top     = `DSP_TOP_9BIT;
            wr_mask = `DSP_TOP_9BIT;
         end
         `DSP_WM_PC10: begin
            pc_mode = 1'b1;
            top     = `DSP_TOP_10BIT;
            wr_mask = `DSP_TOP_10BIT;
         end
         `DSP_WM_PC_CAP: begin
            pc_mode = 1'b1;
            top     = capture_value_register; // see RULE4
         end
         `DSP_WM_PC_CMPA: begin
            pc_mode = 1'b1;
            top     = compare_register_a;
         end
         `DSP_WM_PFC_CAP: begin
            pfc_mode = 1'b1; // see RULE14
            top      = capture_value_register; // see RULE15
         end
         `DSP_WM_PFC_CMPA: begin
            pfc_mode = 1'b1;
            top      = compare_register_a;
         end
         default: pc_mode = 1'b0;
      endcase
   end

   assign dual      = pc_mode | pfc_mode;
   assign at_top    = timer_tick & dual & (counter_value == top);
   assign at_bottom = timer_tick & dual & (counter_value == `DSP_BOTTOM);
   assign match_a   = timer_tick & dual & (counter_value == compare_register_a);
   assign match_b   = timer_tick & dual & (counter_value == compare_register_b);
   assign top_cap   = (wm == `DSP_WM_PC_CAP) | (wm == `DSP_WM_PFC_CAP);
   assign top_cmpa  = (wm == `DSP_WM_PC_CMPA) | (wm == `DSP_WM_PFC_CMPA);
   assign toggle_ok = top_cmpa & (ctrl.output_mode_bits_a == `DSP_OM_TOGGLE);

   // ****************************************
   // APB decode
   // ****************************************
   assign setup  = psel & ~penable;
   assign wr     = psel & penable & pwrite & mapped;
   assign wr_cnt = wr & (paddr == `DSP_OFF_COUNT);
   assign pready = 1'b1;

   always_comb begin
      case (paddr)
         `DSP_OFF_CTRL, `DSP_OFF_COUNT, `DSP_OFF_CMPA,
         `DSP_OFF_CMPB, `DSP_OFF_CAPT, `DSP_OFF_FLAGS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~mapped;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         case (paddr)
            `DSP_OFF_CTRL:  prdata <= {22'h000000, ctrl};
            `DSP_OFF_COUNT: prdata <= {16'h0000, counter_value};
            `DSP_OFF_CMPA:  prdata <= {16'h0000, cmp_buf_a};
            `DSP_OFF_CMPB:  prdata <= {16'h0000, cmp_buf_b};
            `DSP_OFF_CAPT:  prdata <= {16'h0000, capture_value_register};
            `DSP_OFF_FLAGS: prdata <= {28'h0000000, flags};
            default:        prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl <= `DSP_CTRL_RST;
      end else if (wr && paddr == `DSP_OFF_CTRL) begin
         ctrl <= pwdata[9:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         capture_value_register <= `DSP_CMP_RST;
      end else if (wr && paddr == `DSP_OFF_CAPT) begin
         capture_value_register <= pwdata[15:0];
      end
   end

   // Buffered compare values, masked under fixed TOP
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cmp_buf_a <= `DSP_CMP_RST;
         cmp_buf_b <= `DSP_CMP_RST;
      end else begin
         if (wr && paddr == `DSP_OFF_CMPA) begin
            cmp_buf_a <= pwdata[15:0] & wr_mask; // see RULE8
         end
         if (wr && paddr == `DSP_OFF_CMPB) begin
            cmp_buf_b <= pwdata[15:0] & wr_mask;
         end
      end
   end

   // ****************************************
   // Double-buffer update
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         compare_register_a <= `DSP_CMP_RST;
         compare_register_b <= `DSP_CMP_RST;
      end else if (!dual) begin
         compare_register_a <= cmp_buf_a;
         compare_register_b <= cmp_buf_b;
      end else if ((pc_mode && at_top) || (pfc_mode && at_bottom)) begin
         compare_register_a <= cmp_buf_a; // see RULE7 see RULE9 see RULE16
         compare_register_b <= cmp_buf_b;
      end
   end

   // ****************************************
   // Dual-slope counter
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         counter_value <= `DSP_CNT_RST;
         dir           <= DSP_UP;
      end else if (wr_cnt) begin
         counter_value <= pwdata[15:0];
      end else if (timer_tick && dual) begin // see RULE22
         if (dir == DSP_UP) begin
            if (counter_value == top) begin
               dir           <= DSP_DOWN; // see RULE3
               counter_value <= counter_value - 16'h0001;
            end else begin
               counter_value <= counter_value + 16'h0001; // see RULE1
            end
         end else begin
            if (counter_value == `DSP_BOTTOM) begin
               dir           <= DSP_UP;
               counter_value <= counter_value + 16'h0001;
            end else begin
               counter_value <= counter_value - 16'h0001;
            end
         end
      end
   end

   // ****************************************
   // Flags, write one to clear, set wins
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flags <= `DSP_FLG_RST;
      end else begin
         if (wr && paddr == `DSP_OFF_FLAGS) begin
            flags <= flags & ~dsp_flags_t'(pwdata[3:0]);
         end
         if (at_bottom) begin
            flags.overflow_flag <= 1'b1; // see RULE6 see RULE16
         end
         if (match_a || (at_top && top_cmpa)) begin
            flags.cmp_flag_a <= 1'b1; // see RULE17 see RULE18
         end
         if (match_b) begin
            flags.cmp_flag_b <= 1'b1; // see RULE18
         end
         if (at_top && top_cap) begin
            flags.capture_flag <= 1'b1; // see RULE7 see RULE17
         end
      end
   end

   // ****************************************
   // Compare output waveform
   // ****************************************
   function automatic logic next_level(input logic [1:0] om, input logic cur,
         input logic [15:0] cmp, input logic [15:0] t, input dsp_dir_t d);
      logic lvl;
      lvl = cur;
      if (cmp == t) begin
         lvl = 1'b1; // see RULE12 see RULE19
      end else if (cmp == `DSP_BOTTOM) begin
         lvl = 1'b0;
      end else begin
         lvl = (d == DSP_DOWN); // see RULE5
      end
      if (om == `DSP_OM_INV) begin
         lvl = ~lvl; // see RULE21
      end
      return lvl;
   endfunction

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         compare_output_a <= 1'b0;
      end else if (match_a) begin
         if (toggle_ok) begin
            compare_output_a <= ~compare_output_a; // see RULE13 see RULE20
         end else if (ctrl.output_mode_bits_a[1]) begin
            compare_output_a <= next_level(ctrl.output_mode_bits_a,
               compare_output_a, compare_register_a, top, dir);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         compare_output_b <= 1'b0;
      end else if (match_b && ctrl.output_mode_bits_b[1]) begin
         compare_output_b <= next_level(ctrl.output_mode_bits_b,
            compare_output_b, compare_register_b, top, dir);
      end
   end

   // Pin driven only when connected and direction is output
   assign compare_output_a_oe = ctrl.pin_direction_bit_a & dual
      & (ctrl.output_mode_bits_a[1] | toggle_ok); // see RULE21
   assign compare_output_b_oe = ctrl.pin_direction_bit_b & dual
      & ctrl.output_mode_bits_b[1];

   // ****************************************
   // Assertions
   // ****************************************
   property p_dir_bottom;
      @(posedge ref_clk) disable iff (!rst_n)
      timer_tick && dual && !wr_cnt && dir == DSP_DOWN && counter_value == 16'h0000
      |=> dir == DSP_UP && counter_value == 16'h0001;
   endproperty
   a_dir_bottom: assert property (p_dir_bottom) else $error("no turn at bottom"); // see RULE1

   property p_top_fixed;
      @(posedge ref_clk) disable iff (!rst_n)
      wm == 4'h2 |-> top == 16'h01FF;
   endproperty
   a_top_fixed: assert property (p_top_fixed) else $error("wrong fixed top"); // see RULE2

   property p_top_turn;
      @(posedge ref_clk) disable iff (!rst_n)
      at_top && !wr_cnt && dir == DSP_UP && top > 16'h0001
      |=> dir == DSP_DOWN && counter_value == $past(top) - 16'h0001;
   endproperty
   a_top_turn: assert property (p_top_turn) else $error("bad top turn"); // see RULE3

   property p_ovf;
      @(posedge ref_clk) disable iff (!rst_n)
      at_bottom |=> flags.overflow_flag;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not set"); // see RULE6

   property p_pc_load;
      @(posedge ref_clk) disable iff (!rst_n)
      pc_mode && at_top && top_cap
      |=> compare_register_b == $past(cmp_buf_b) && flags.capture_flag;
   endproperty
   a_pc_load: assert property (p_pc_load) else $error("no load at top"); // see RULE7

   property p_mask;
      @(posedge ref_clk) disable iff (!rst_n)
      wr && paddr == 8'h08 && wm == 4'h1 |=> cmp_buf_a[15:8] == 8'h00;
   endproperty
   a_mask: assert property (p_mask) else $error("high bits kept"); // see RULE8

   property p_clear_up;
      @(posedge ref_clk) disable iff (!rst_n)
      match_a && !toggle_ok && ctrl.output_mode_bits_a == 2'h2 && dir == DSP_UP
      && compare_register_a != top && compare_register_a != 16'h0000
      |=> !compare_output_a;
   endproperty
   a_clear_up: assert property (p_clear_up) else $error("no clear on up"); // see RULE5

   property p_toggle;
      @(posedge ref_clk) disable iff (!rst_n)
      match_a && toggle_ok |=> compare_output_a != $past(compare_output_a);
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle"); // see RULE13

   property p_pfc_load;
      @(posedge ref_clk) disable iff (!rst_n)
      pfc_mode && at_bottom
      |=> compare_register_a == $past(cmp_buf_a) && flags.overflow_flag;
   endproperty
   a_pfc_load: assert property (p_pfc_load) else $error("no load at bottom"); // see RULE16

   property p_cmp_flag;
      @(posedge ref_clk) disable iff (!rst_n)
      match_b |=> flags.cmp_flag_b;
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag lost"); // see RULE18

   property p_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      !timer_tick && !wr_cnt |=> $stable(counter_value) && $stable(dir);
   endproperty
   a_hold: assert property (p_hold) else $error("moved without tick"); // see RULE22

   property p_off;
      @(posedge ref_clk) disable iff (!rst_n)
      ctrl.output_mode_bits_b == 2'h0 |-> !compare_output_b_oe;
   endproperty
   a_off: assert property (p_off) else $error("pin driven when off"); // see RULE21

   c_top: cover property (@(posedge ref_clk) disable iff (!rst_n) at_top ##[1:300] at_bottom);
   c_tog: cover property (@(posedge ref_clk) disable iff (!rst_n) match_a && toggle_ok);
   c_pfc: cover property (@(posedge ref_clk) disable iff (!rst_n) pfc_mode && at_bottom);
endmodule

// [tb/dsp_load.sv]
// Model of the external load on one compare output pin
`timescale 1ns/1ps
module dsp_load (
   // Pin as driven by the timer
   input  wire logic pin,
   input  wire logic pin_oe,
   // Level seen by the load
   output logic      level
);
   // Pull-down holds an undriven pin low
   assign level = pin_oe ? pin : 1'b0;
endmodule

// [tb/dsp_pwm_timer_tb_top.sv]
// Self-checking bench for the dual-slope PWM timer
`timescale 1ns/1ps
`include "dsp_params.svh"
module dsp_pwm_timer_tb_top import dsp_pkg::*; ;
   logic        ref_clk, rst_n, timer_tick, psel, penable, pwrite;
   logic        pready, pslverr, oa, oa_oe, ob, ob_oe, lvl_a, lvl_b;
   logic        up, o_a, o_b, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [31:0] seed = 32'h313B;
   logic [15:0] cnt, top, capt, buf_a, buf_b, act_a, act_b;
   dsp_ctrl_t   ctrl;
   dsp_flags_t  flg;
   int          error_cnt = 0;
   int          compares = 0;
   logic [3:0]  modes [7] = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'h8, 4'h9};

   dsp_pwm_timer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .timer_tick(timer_tick), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .compare_output_a(oa), .compare_output_a_oe(oa_oe),
      .compare_output_b(ob), .compare_output_b_oe(ob_oe));
   dsp_load load_a (.pin(oa), .pin_oe(oa_oe), .level(lvl_a));
   dsp_load load_b (.pin(ob), .pin_oe(ob_oe), .level(lvl_b));

   // ****************************************
   // Reference model
   // ****************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic cap_top(logic [3:0] m);
      return m == `DSP_WM_PFC_CAP || m == `DSP_WM_PC_CAP;
   endfunction
   function automatic logic a_top(logic [3:0] m);
      return m == `DSP_WM_PFC_CMPA || m == `DSP_WM_PC_CMPA;
   endfunction
   function automatic logic [15:0] top_of(logic [3:0] m);
      case (m)
         `DSP_WM_PC8:  return `DSP_TOP_8BIT;
         `DSP_WM_PC9:  return `DSP_TOP_9BIT;
         `DSP_WM_PC10: return `DSP_TOP_10BIT;
         default:      return cap_top(m) ? capt : act_a;
      endcase
   endfunction
   function automatic logic [15:0] pick(logic [15:0] t);
      logic [31:0] r;
      r = rnd();
      return r[1:0] == 2'h0 ? 16'h0000 : r[1:0] == 2'h1 ? t : 16'(r[31:16] % (t + 16'h1));
   endfunction
   function automatic logic pin_next(logic o, logic [1:0] om, logic [15:0] c, logic tg);
      if (om == `DSP_OM_TOGGLE) return tg ? ~o : o;
      if (om == `DSP_OM_OFF) return o;
      return (c == top || (c != 16'h0000 && !up)) ^ (om == `DSP_OM_INV);
   endfunction
   function automatic logic oe_exp(logic d, logic [1:0] om, logic tg);
      return d && (ctrl.waveform_mode_select inside {[4'h1:4'h3], [4'h8:4'hB]})
         && (om[1] || (om == `DSP_OM_TOGGLE && tg));
   endfunction

   task automatic step();
      logic [3:0] m;
      m = ctrl.waveform_mode_select;
      top = top_of(m);
      if (cnt == act_a) begin
         flg.cmp_flag_a = 1'b1;
         o_a = pin_next(o_a, ctrl.output_mode_bits_a, act_a, a_top(m));
      end
      if (cnt == act_b) begin
         flg.cmp_flag_b = 1'b1;
         o_b = pin_next(o_b, ctrl.output_mode_bits_b, act_b, 1'b0);
      end
      if (cnt == top && cap_top(m)) flg.capture_flag = 1'b1;
      if (cnt == 16'h0000) flg.overflow_flag = 1'b1;
      if (cnt == ((m inside {4'h8, 4'h9}) ? 16'h0000 : top)) begin
         act_a = buf_a;
         act_b = buf_b;
      end
      if (cnt == top) up = 1'b0;
      else if (cnt == 16'h0000) up = 1'b1;
      cnt = up ? cnt + 16'h1 : cnt - 16'h1;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for pready
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic check_regs();
      bus(1'b0, `DSP_OFF_COUNT, 32'h0);
      chk("count", 32'(cnt), rd);
      bus(1'b0, `DSP_OFF_FLAGS, 32'h0);
      chk("flags", 32'(flg), rd);
      bus(1'b1, `DSP_OFF_FLAGS, 32'hF);
      flg = '0;
   endtask

   task automatic run(input int n);
      logic [31:0] r;
      logic        t, ea, eb;
      for (int i = 0; i < n; i++) begin
         r = rnd();
         t = r[1:0] != 2'h0;
         timer_tick <= t;
         @(posedge ref_clk);
         ea = oe_exp(ctrl.pin_direction_bit_a, ctrl.output_mode_bits_a,
                     a_top(ctrl.waveform_mode_select));
         eb = oe_exp(ctrl.pin_direction_bit_b, ctrl.output_mode_bits_b, 1'b0);
         chk("pin a", 32'({ea, ea & o_a}), 32'({oa_oe, lvl_a}));
         chk("pin b", 32'({eb, eb & o_b}), 32'({ob_oe, lvl_b}));
         if (t) step();
         if (i % 16 == 15) begin
            timer_tick <= 1'b0;
            check_regs();
         end
      end
      timer_tick <= 1'b0;
   endtask

   task automatic config_run(input logic [3:0] m, input logic p);
      logic [15:0] t0, t1;
      logic [31:0] r;
      ctrl = '0;
      bus(1'b1, `DSP_OFF_CTRL, 32'h0);
      bus(1'b1, `DSP_OFF_COUNT, 32'h0);
      cnt = 16'h0000;
      up = 1'b1;
      r = rnd();
      t0 = (cap_top(m) || a_top(m)) ? 16'(r % 30 + 3) : top_of(m);
      capt = cap_top(m) ? t0 : r[31:16];
      buf_a = a_top(m) ? t0 : pick(t0);
      buf_b = pick(t0);
      act_a = buf_a;
      act_b = buf_b;
      bus(1'b1, `DSP_OFF_CAPT, 32'(capt));
      bus(1'b1, `DSP_OFF_CMPA, 32'(buf_a));
      bus(1'b1, `DSP_OFF_CMPB, 32'(buf_b));
      r = rnd();
      ctrl = {r[0] | p, r[1] | ~p, r[3:2], p ? 2'h1 : {1'b1, r[4]}, m};
      bus(1'b1, `DSP_OFF_CTRL, 32'(ctrl));
      if (!(cap_top(m) || a_top(m))) begin
         bus(1'b1, `DSP_OFF_CMPA, 32'hFFFF);
         bus(1'b0, `DSP_OFF_CMPA, 32'h0);
         chk("masked compare", 32'(t0), rd);
         bus(1'b1, `DSP_OFF_CMPA, 32'(buf_a));
      end
      run(32'(t0) + 4);
      t1 = t0 + 16'(r[7:5]);
      if (a_top(m)) begin
         buf_a = t1;
         bus(1'b1, `DSP_OFF_CMPA, 32'(t1));
      end
      if (cap_top(m)) begin
         capt = t1;
         bus(1'b1, `DSP_OFF_CAPT, 32'(t1));
      end
      run(2 * 32'(t1) + 12);
      $display("test mode %0d pass %0d done", m, p);
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      error_cnt++;
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      timer_tick = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {o_a, o_b, up, cnt, capt, act_a, act_b} = '0;
      flg = '0;
      ctrl = '0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", 32'h0, rd);
      end
      bus(1'b1, 8'h18, 32'h5);
      bus(1'b0, 8'h18, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], er});
      $display("test reset and map done");
      for (int p = 0; p < 2; p++)
         foreach (modes[k]) config_run(modes[k], 1'(p));
      close_out();
   end
endmodule
